// file: src/bcp_port.sv
// bus capable port zero: 16-line port with data/direction halves, start-up
// strap capture and the bus controller's address/data sequencing.
// assumes synchronous pin inputs, an external pad resolving out/oe/pullup,
// and an Avalon-MM master on the register side.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps

module bcp_port
    import bcp_pkg::*;
#(
    parameter int unsigned ADDR_W = 18
) (
    input  wire logic               I_CORE_CLK,
    input  wire logic               I_RST_N,
    input  wire logic [ADDR_W-1:0]  I_AVS_ADDRESS,
    input  wire logic               I_AVS_READ,
    input  wire logic               I_AVS_WRITE,
    input  wire logic [31:0]        I_AVS_WRITEDATA,
    input  wire logic [3:0]         I_AVS_BYTEENABLE,
    output logic      [31:0]        O_AVS_READDATA,
    output logic                    O_AVS_WAITREQUEST,
    input  wire logic [15:0]        I_PIN_IN,
    output logic      [15:0]        O_PIN_OUT,
    output logic      [15:0]        O_PIN_OE,
    output logic                    O_PULLUP_EN,
    input  wire logic [15:0]        I_ALT_OUT,
    output logic      [15:0]        O_ALT_IN,
    input  wire bcp_ext_req_t       I_EXT_REQ,
    output bcp_ext_rsp_t            O_EXT_RSP
);

    generate
        if (ADDR_W < 18) begin : g_chk
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    // bits that the bus controller owns in the current mode
    function automatic logic [15:0] f_own(input logic [2:0] cfg);
        if (!cfg[CFG_EN_BIT])
            return MASK_NONE;
        else if (cfg[CFG_MODE_LSB+:2] == MODE_DMX8)
            return MASK_LOW;
        else
            return MASK_ALL;
    endfunction

    function automatic logic [15:0] f_dir(input logic [2:0]  cfg,
                                          input logic [15:0] dir,
                                          input bcp_fsm_t    fsm,
                                          input logic        wr);
        logic [15:0] own;
        logic [15:0] bus;
        own = f_own(cfg);
        bus = MASK_NONE;
        if (fsm == ST_ADDR)
            bus = MASK_ALL;
        else if (fsm == ST_DATA && wr)
            bus = cfg[CFG_MODE_LSB+1] ? MASK_ALL : MASK_LOW;
        return (dir & ~own) | (bus & own);
    endfunction

    bcp_state_t st_q;
    bcp_state_t st_d;

    logic [15:0] idx;
    logic        go;
    logic        mux_m;
    logic        w8_m;
    logic [15:0] own_q;
    logic [15:0] dcur;

    assign idx   = 16'(I_AVS_ADDRESS >> 2);
    assign mux_m = st_q.cfg[CFG_MODE_LSB];
    assign w8_m  = !st_q.cfg[CFG_MODE_LSB+1];
    assign own_q = f_own(st_q.cfg);
    assign dcur  = f_dir(st_q.cfg, st_q.dir, st_q.fsm, st_q.req.wr);
    assign go    = st_q.fsm == ST_IDLE && I_EXT_REQ.valid
                   && st_q.cfg[CFG_EN_BIT] && !st_q.in_rst;

    always_comb begin
        logic [15:0] rdv;
        logic [15:0] wv;
        rdv  = (dcur & st_q.lat) | (~dcur & st_q.pin);
        wv   = MASK_NONE;
        st_d = st_q;
        st_d.pin = I_PIN_IN;
        st_d.rsp.done = 1'b0;

        // strap capture on the first cycle after reset release
        if (st_q.in_rst) begin
            st_d.cfg    = {1'b1, I_PIN_IN[PIN_MODE_LSB+:2]};
            st_d.copy   = I_PIN_IN[PIN_COPY_LSB+:8];
            st_d.in_rst = 1'b0;
            st_d.pull   = 1'b0;
        end

        // one wait cycle per access keeps read data a clean flop
        if ((I_AVS_READ || I_AVS_WRITE) && st_q.wreq) begin
            st_d.wreq = 1'b0;
            case (idx)
                IDX_LOW_DATA:     st_d.rdat = {8'h00, rdv[7:0]};
                IDX_HIGH_DATA:    st_d.rdat = {8'h00, rdv[15:8]};
                IDX_LOW_DIR:      st_d.rdat = {8'h00, st_q.dir[7:0]};
                IDX_HIGH_DIR:     st_d.rdat = {8'h00, st_q.dir[15:8]};
                IDX_BUS_CFG0:     st_d.rdat = {13'h0000, st_q.cfg};
                IDX_STARTUP_COPY: st_d.rdat = {8'h00, st_q.copy};
                default:          st_d.rdat = 16'h0000;
            endcase
        end else begin
            st_d.wreq = 1'b1;
        end

        // bus-owned data latch halves ignore software writes so a transfer cannot be torn
        if (I_AVS_WRITE && !st_q.wreq && I_AVS_BYTEENABLE[0]) begin
            case (idx)
                IDX_LOW_DATA: begin
                    if (!own_q[0])
                        st_d.lat[7:0] = I_AVS_WRITEDATA[7:0];
                end
                IDX_HIGH_DATA: begin
                    if (!own_q[8])
                        st_d.lat[15:8] = I_AVS_WRITEDATA[7:0];
                end
                IDX_LOW_DIR:  st_d.dir[7:0]  = I_AVS_WRITEDATA[7:0];
                IDX_HIGH_DIR: st_d.dir[15:8] = I_AVS_WRITEDATA[7:0];
                IDX_BUS_CFG0: st_d.cfg = I_AVS_WRITEDATA[CFG_W-1:0];
                default: begin
                end
            endcase
        end

        case (st_q.fsm)
            ST_IDLE: begin
                if (go) begin
                    st_d.req      = I_EXT_REQ;
                    st_d.hi       = 1'b0;
                    st_d.rsp.busy = 1'b1;
                    if (mux_m) begin
                        st_d.fsm        = ST_ADDR;
                        st_d.rsp.aphase = 1'b1;
                        wv = I_EXT_REQ.addr;
                    end else begin
                        st_d.fsm = ST_DATA;
                        wv = w8_m ? {8'h00, I_EXT_REQ.wdata[7:0]}
                                  : I_EXT_REQ.wdata;
                    end
                    st_d.lat = (st_q.lat & ~own_q) | (wv & own_q);
                end
            end
            ST_ADDR: begin
                st_d.fsm        = ST_DATA;
                st_d.rsp.aphase = 1'b0;
                if (!w8_m)
                    wv = st_q.req.wdata;
                else if (st_q.hi)
                    wv = {8'h00, st_q.req.wdata[15:8]};
                else
                    wv = {8'h00, st_q.req.wdata[7:0]};
                st_d.lat = (st_q.lat & ~own_q) | (wv & own_q);
            end
            ST_DATA: begin
                if (!st_q.req.wr) begin
                    if (!w8_m)
                        st_d.rsp.rdata = I_PIN_IN;
                    else if (st_q.hi)
                        st_d.rsp.rdata[15:8] = I_PIN_IN[7:0];
                    else
                        st_d.rsp.rdata[7:0] = I_PIN_IN[7:0];
                end
                if (w8_m && st_q.req.word && !st_q.hi) begin
                    st_d.hi = 1'b1;
                    if (mux_m) begin
                        st_d.fsm        = ST_ADDR;
                        st_d.rsp.aphase = 1'b1;
                        wv = st_q.req.addr | 16'h0001;
                    end else begin
                        wv = {8'h00, st_q.req.wdata[15:8]};
                    end
                    st_d.lat = (st_q.lat & ~own_q) | (wv & own_q);
                end else begin
                    st_d.fsm      = ST_IDLE;
                    st_d.rsp.busy = 1'b0;
                    st_d.rsp.done = 1'b1;
                end
            end
            default: st_d.fsm = ST_IDLE;
        endcase

        // pad outputs are registered from the next state
        st_d.poe  = f_dir(st_d.cfg, st_d.dir, st_d.fsm, st_d.req.wr);
        st_d.pout = st_d.lat & (f_own(st_d.cfg) | I_ALT_OUT);
        st_d.alt  = (st_d.poe & st_d.lat) | (~st_d.poe & I_PIN_IN);
        if (st_q.in_rst)
            st_d.poe = MASK_NONE;
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            st_q        <= '0;
            st_q.lat    <= {RST_DATA, RST_DATA};
            st_q.dir    <= {RST_DIR, RST_DIR};
            st_q.cfg    <= RST_CFG;
            st_q.copy   <= RST_COPY;
            st_q.pull   <= 1'b1;
            st_q.in_rst <= 1'b1;
            st_q.wreq   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign O_AVS_READDATA    = {16'h0000, st_q.rdat};
    assign O_AVS_WAITREQUEST = st_q.wreq;
    assign O_PIN_OUT         = st_q.pout;
    assign O_PIN_OE          = st_q.poe;
    assign O_PULLUP_EN       = st_q.pull;
    assign O_ALT_IN          = st_q.alt;
    assign O_EXT_RSP         = st_q.rsp;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    property p_rst_pull;
        st_q.in_rst |-> O_PULLUP_EN && O_PIN_OE == 16'h0000;
    endproperty
    a_rst_pull: assert property (p_rst_pull)
        else $error("pullups off or driver on while in reset");

    property p_strap;
        $fell(st_q.in_rst) |-> st_q.copy == $past(I_PIN_IN[15:8])
            && st_q.cfg[1:0] == $past(I_PIN_IN[7:6]) && st_q.cfg[2];
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap capture wrong at reset end");

    property p_pull_off;
        $fell(st_q.in_rst) |-> !O_PULLUP_EN;
    endproperty
    a_pull_off: assert property (p_pull_off)
        else $error("pullups still on after reset");

    property p_gpio_dir;
        !st_q.cfg[CFG_EN_BIT] && !st_q.in_rst |-> O_PIN_OE == st_q.dir;
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("driver enable differs from direction");

    property p_dir_back;
        $fell(st_q.cfg[CFG_EN_BIT]) |=> O_PIN_OE == $past(st_q.dir, 2);
    endproperty
    a_dir_back: assert property (p_dir_back)
        else $error("direction not restored after bus mode");

    property p_and;
        (O_PIN_OUT & ~st_q.lat) == 16'h0000;
    endproperty
    a_and: assert property (p_and)
        else $error("pin high while latch low");

    property p_loop;
        ((O_ALT_IN ^ st_q.lat) & O_PIN_OE) == 16'h0000;
    endproperty
    a_loop: assert property (p_loop)
        else $error("alternate input differs from latch on output");

    property p_mux_rd;
        go && mux_m && !I_EXT_REQ.wr |=> O_EXT_RSP.aphase
            && O_PIN_OE == (own_q | (st_q.dir & ~own_q))
            ##1 !O_EXT_RSP.aphase && (O_PIN_OE & own_q) == 16'h0000;
    endproperty
    a_mux_rd: assert property (p_mux_rd)
        else $error("mux read did not drive address then float");

    property p_mux_wr;
        go && mux_m && !w8_m && I_EXT_REQ.wr |=> O_PIN_OUT == st_q.req.addr
            ##1 O_PIN_OUT == st_q.req.wdata && O_PIN_OE == 16'hffff;
    endproperty
    a_mux_wr: assert property (p_mux_wr)
        else $error("mux write data not after address");

    property p_w8_word;
        go && mux_m && w8_m && I_EXT_REQ.word
            |=> !O_EXT_RSP.done [*4] ##1 O_EXT_RSP.done;
    endproperty
    a_w8_word: assert property (p_w8_word)
        else $error("8-bit word access not two memory cycles");

    property p_dmx_rd;
        go && !mux_m && !w8_m && !I_EXT_REQ.wr |=> !O_EXT_RSP.aphase
            && O_PIN_OE == 16'h0000
            ##1 O_EXT_RSP.done && O_EXT_RSP.rdata == $past(I_PIN_IN);
    endproperty
    a_dmx_rd: assert property (p_dmx_rd)
        else $error("demux read not data only");

    property p_half;
        I_AVS_WRITE && !O_AVS_WAITREQUEST && idx == IDX_LOW_DATA
            && st_q.fsm == ST_IDLE && !st_q.cfg[CFG_EN_BIT]
            |=> st_q.lat[15:8] == $past(st_q.lat[15:8]);
    endproperty
    a_half: assert property (p_half)
        else $error("low half write changed high half");

    // directions come out of reset as inputs
    property p_rst_dir;
        $fell(st_q.in_rst) |-> st_q.dir == 16'h0000;
    endproperty
    a_rst_dir: assert property (p_rst_dir)
        else $error("direction not input after reset");

    // the input latch follows the pins with one cycle of delay
    property p_sample;
        !st_q.in_rst |-> st_q.pin == $past(I_PIN_IN);
    endproperty
    a_sample: assert property (p_sample)
        else $error("input latch missed a pin sample");

    // pullups stay off for the whole of normal operation
    property p_pull_hold;
        !st_q.in_rst |-> !O_PULLUP_EN;
    endproperty
    a_pull_hold: assert property (p_pull_hold)
        else $error("pullups on outside reset");

    // in 8-bit demux mode the high half keeps its software direction
    property p_dmx8_free;
        st_q.cfg[CFG_EN_BIT] && st_q.cfg[1:0] == MODE_DMX8
            && !st_q.in_rst |-> O_PIN_OE[15:8] == st_q.dir[15:8];
    endproperty
    a_dmx8_free: assert property (p_dmx8_free)
        else $error("high half taken by 8-bit demux bus");

    property p_dmx_wr;
        go && !mux_m && I_EXT_REQ.wr |=> !O_EXT_RSP.aphase
            && O_PIN_OE[7:0] == 8'hff;
    endproperty
    a_dmx_wr: assert property (p_dmx_wr)
        else $error("demux write did not drive data at once");

    c_w8_word: cover property (go && mux_m && w8_m && I_EXT_REQ.word);
    c_dmx_rd: cover property (go && !mux_m && !I_EXT_REQ.wr);
    c_avs_wr: cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
    c_mux_wr: cover property (go && mux_m && I_EXT_REQ.wr);

endmodule // bcp_port

// file: common/bcp_pkg.sv
// bus capable port zero: register map, field layout, modes and carriers.
// assumes a 16-line port split into two byte halves.
package bcp_pkg;

    localparam int unsigned PORT_W = 16;
    localparam int unsigned HALF_W = 8;

    // register indices; the byte address on the bus is four times these
    localparam logic [15:0] IDX_LOW_DATA     = 16'hff00;
    localparam logic [15:0] IDX_HIGH_DATA    = 16'hff02;
    localparam logic [15:0] IDX_LOW_DIR      = 16'hff04;
    localparam logic [15:0] IDX_HIGH_DIR     = 16'hff06;
    localparam logic [15:0] IDX_BUS_CFG0     = 16'hff08;
    localparam logic [15:0] IDX_STARTUP_COPY = 16'hff0a;

    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'h00;
    localparam logic [2:0] RST_CFG  = 3'h0;
    localparam logic [7:0] RST_COPY = 8'h00;

    // bus_config_zero fields
    localparam int unsigned CFG_W        = 3;
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_EN_BIT   = 2;
    // start-up straps on the port lines
    localparam int unsigned PIN_MODE_LSB = 6;
    localparam int unsigned PIN_COPY_LSB = 8;

    localparam logic [1:0] MODE_DMX8  = 2'h0;
    localparam logic [1:0] MODE_MUX8  = 2'h1;
    localparam logic [1:0] MODE_DMX16 = 2'h2;
    localparam logic [1:0] MODE_MUX16 = 2'h3;

    localparam logic [15:0] MASK_ALL  = 16'hffff;
    localparam logic [15:0] MASK_LOW  = 16'h00ff;
    localparam logic [15:0] MASK_NONE = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } bcp_fsm_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bcp_ext_req_t;

    typedef struct packed {
        logic        done;
        logic        busy;
        logic        aphase;
        logic [15:0] rdata;
    } bcp_ext_rsp_t;

    typedef struct packed {
        logic [15:0]  lat;
        logic [15:0]  dir;
        logic [15:0]  pin;
        logic [15:0]  pout;
        logic [15:0]  poe;
        logic [15:0]  alt;
        logic [2:0]   cfg;
        logic [7:0]   copy;
        logic         pull;
        logic         in_rst;
        logic         wreq;
        logic [15:0]  rdat;
        bcp_fsm_t     fsm;
        logic         hi;
        bcp_ext_req_t req;
        bcp_ext_rsp_t rsp;
    } bcp_state_t;

endpackage

// file: tb/bcp_mem_model.sv
// external memory on the bus port's address/data lines.
// assumes the bench resolves the pins and supplies the demux address.
`timescale 1ns/100ps

module bcp_mem_model
    import bcp_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_mux,
    input  wire logic         i_wide,
    input  wire logic [15:0]  i_dmx_addr,
    input  wire logic [15:0]  i_pin,
    input  wire logic [15:0]  i_oe,
    input  wire bcp_ext_rsp_t i_rsp,
    output logic      [15:0]  o_d,
    output logic      [15:0]  o_oe
);
    logic [7:0]  mem [256];
    logic [15:0] adr_q;
    logic        cnt_q;
    logic [7:0]  ea;
    logic        dcyc;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 3 + 1);
        end
    end

    // demux has no address on the port; the second byte follows the first
    assign ea   = i_mux ? adr_q[7:0] : i_dmx_addr[7:0] + {7'h0, cnt_q};
    assign dcyc = i_rsp.busy && !i_rsp.aphase;
    // answer only in data cycles on lines the port has released
    assign o_oe = (dcyc ? ~i_oe : 16'h0000) &
                  (i_wide ? 16'hffff : 16'h00ff);
    assign o_d  = {mem[ea | 8'h01], mem[ea]};

    always @(posedge i_clk) begin
        if (i_rsp.aphase)
            adr_q <= i_pin;
        cnt_q <= i_rsp.busy;
        if (dcyc && i_oe[0] === 1'b1) begin
            mem[ea] <= i_pin[7:0];
            if (i_wide)
                mem[ea | 8'h01] <= i_pin[15:8];
        end
    end
endmodule // bcp_mem_model

// file: tb/tb_top.sv
// bench for the bus capable port: registers, gpio, straps and bus modes.
// assumes the memory model on the port lines and straps set by pulldowns.
`timescale 1ns/100ps

module tb_top;
    import bcp_pkg::*;
    localparam logic [15:0] STRAP = 16'h5abf;
    logic         clk;
    logic         rst_n;
    logic [17:0]  addr;
    logic         rd;
    logic         wr;
    logic [31:0]  wd;
    logic [31:0]  rdat;
    logic         wreq;
    logic [15:0]  pin;
    logic [15:0]  pout;
    logic [15:0]  poe;
    logic         pu;
    logic [15:0]  alt_out;
    logic [15:0]  alt_in;
    bcp_ext_req_t req;
    bcp_ext_rsp_t rsp;
    logic [15:0]  mem_d;
    logic [15:0]  mem_oe;
    logic [15:0]  ext_d;
    logic [15:0]  ext_oe;
    logic [15:0]  last_q;
    logic         mux;
    logic         wide;
    int           fail_count;
    int           comparisons;

    bcp_port dut (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
        .I_AVS_BYTEENABLE(4'h1), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wreq), .I_PIN_IN(pin), .O_PIN_OUT(pout),
        .O_PIN_OE(poe), .O_PULLUP_EN(pu), .I_ALT_OUT(alt_out),
        .O_ALT_IN(alt_in), .I_EXT_REQ(req), .O_EXT_RSP(rsp)
    );
    bcp_mem_model mem (
        .i_clk(clk), .i_mux(mux), .i_wide(wide), .i_dmx_addr(req.addr),
        .i_pin(pin), .i_oe(poe), .i_rsp(rsp), .o_d(mem_d), .o_oe(mem_oe)
    );

    // undriven lines show the strap during reset, else a changing level
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (poe[i] === 1'b1) pin[i] = pout[i];
            else if (mem_oe[i] === 1'b1) pin[i] = mem_d[i];
            else if (ext_oe[i]) pin[i] = ext_d[i];
            else if (rst_n !== 1'b1 || pu === 1'b1) pin[i] = STRAP[i];
            else pin[i] = ~last_q[i];
        end
    end
    always @(posedge clk) last_q <= pin;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task stop_test();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task av(input logic w, input logic [15:0] idx, input logic [7:0] d,
            output logic [31:0] q);
        @(posedge clk);
        addr <= {idx, 2'b00};
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        // no wait limit here: only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task wreg(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        av(1'b1, idx, d, q);
    endtask

    task rreg(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] q;
        av(1'b0, idx, 8'h00, q);
        chk(q, {24'h0, e});
    endtask

    // lat is the done cycle counted from the take edge; 12 means none
    task ext(input logic w, input logic [15:0] a, input logic [15:0] d,
             input int lat);
        int k;
        @(posedge clk);
        req <= '{valid: 1'b1, wr: w, word: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        req.valid <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (rsp.aphase === 1'b1) chk(32'(poe), 32'hffff);
        end while (rsp.done !== 1'b1 && k < 12);
        chk(32'(k), 32'(lat));
    endtask

    task t_gpio();
        wreg(IDX_BUS_CFG0, 8'h00);
        wreg(IDX_LOW_DATA, 8'ha5);
        chk(32'(poe), 32'h0000);
        wreg(IDX_LOW_DIR, 8'hff);
        alt_out <= 16'hff0f;
        ext_oe <= 16'hff00;
        ext_d <= 16'h3c00;
        repeat (3) @(posedge clk);
        chk(32'(poe), 32'h00ff);
        chk(32'(pout[7:0]), 32'h05);
        chk(32'(alt_in), 32'h3ca5);
        rreg(IDX_LOW_DATA, 8'ha5);
        rreg(IDX_HIGH_DATA, 8'h3c);
        wreg(IDX_HIGH_DATA, 8'h77);
        rreg(IDX_LOW_DATA, 8'ha5);
        rreg(16'hff0c, 8'h00);
        ext(1'b0, 16'h0010, 16'h0000, 12);
        ext_oe <= 16'h0000;
        wreg(IDX_HIGH_DIR, 8'hff);
        wreg(IDX_BUS_CFG0, 8'h04);
        repeat (3) @(posedge clk);
        chk(32'(poe), 32'hff00);
        chk(32'(pout[15:8]), 32'h77);
    endtask

    task t_bus(input logic [1:0] m, input int lat);
        logic [15:0] a;
        a = 16'h0020 + 16'(2 * m);
        wreg(IDX_BUS_CFG0, {5'h00, 1'b1, m});
        mux <= m[0];
        wide <= m[1];
        ext(1'b0, 16'h0010, 16'h0000, lat);
        chk(32'(rsp.rdata), 32'h3431);
        ext(1'b1, a, 16'hc3a0 + 16'(m), lat);
        ext(1'b0, a, 16'h0000, lat);
        chk(32'(rsp.rdata), 32'(16'hc3a0 + 16'(m)));
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial begin
        fail_count = 0;
        comparisons = 0;
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wd = '0;
        alt_out = 16'hffff;
        req = '0;
        ext_oe = '0;
        ext_d = '0;
        mux = 1'b0;
        wide = 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(pu), 32'h1);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(pu), 32'h0);
        chk(32'(poe), 32'h0000);
        rreg(IDX_BUS_CFG0, 8'h06);
        rreg(IDX_STARTUP_COPY, 8'h5a);
        wreg(IDX_STARTUP_COPY, 8'h00);
        rreg(IDX_STARTUP_COPY, 8'h5a);
        rreg(IDX_LOW_DIR, 8'h00);
        rreg(IDX_HIGH_DIR, 8'h00);
        t_gpio();
        t_bus(MODE_DMX8, 3);
        t_bus(MODE_MUX8, 5);
        t_bus(MODE_DMX16, 2);
        t_bus(MODE_MUX16, 3);
        chk(32'(poe), 32'h0000);
        wreg(IDX_BUS_CFG0, 8'h03);
        repeat (2) @(posedge clk);
        chk(32'(poe), 32'hffff);
        stop_test();
    end
endmodule // tb_top
